// ### hdl/pts_pkg.sv
// constants, types and the timebase for the position pdo transmit scheduler
package pts_pkg;
  localparam int unsigned PTS_CLK_PERIOD_NS = 25;
  localparam int unsigned PTS_MS_NS = 1000000;
  localparam int unsigned PTS_MS_CYCLES = (PTS_MS_NS + PTS_CLK_PERIOD_NS - 1) / PTS_CLK_PERIOD_NS;
  localparam int unsigned PTS_MS_PER_S = 1000;
  localparam int unsigned PTS_REFRESH_HZ = 100;
  localparam int unsigned PTS_REFRESH_MS = PTS_MS_PER_S / PTS_REFRESH_HZ;
  localparam int unsigned PTS_DIV_W = 16;
  localparam int unsigned PTS_REF_W = 4;
  localparam int unsigned PTS_LANES = 4;
  localparam int unsigned PTS_BYTE_W = 8;
  localparam int unsigned PTS_NFAULT = 4;
  localparam logic [11:0] PTS_POS_MID = 12'h800;
  localparam logic [3:0] PTS_POS_PAD = 4'h0;
  localparam logic [16:0] PTS_CYCLE_MAX = 17'h10000;
  localparam logic [16:0] PTS_CYC_LAST = 17'h00001;
  localparam logic [7:0] PTS_TT_SYNC_ACYC = 8'h00;
  localparam logic [7:0] PTS_TT_SYNC_MAX = 8'hF0;
  localparam logic [7:0] PTS_TT_RTR_SYNC = 8'hFC;
  localparam logic [7:0] PTS_TT_RTR_ASYNC = 8'hFD;
  localparam logic [7:0] PTS_TT_ASYNC_MFR = 8'hFE;
  localparam logic [7:0] PTS_TT_RESET = 8'hFF;
  localparam logic [6:0] PTS_NODE_MIN = 7'h01;
  localparam logic [6:0] PTS_NODE_RESET = 7'h01;
  localparam logic [2:0] PTS_RATE_20K = 3'h0;
  localparam logic [2:0] PTS_RATE_800K = 3'h5;
  localparam logic [2:0] PTS_RATE_1M = 3'h6;
  localparam logic [10:0] PTS_COB_PDO = 11'h180;
  localparam logic [10:0] PTS_COB_EMCY = 11'h080;
  localparam logic [7:0] PTS_OFF_TX_TYPE = 8'h00;
  localparam logic [7:0] PTS_OFF_CYCLE = 8'h04;
  localparam logic [7:0] PTS_OFF_NODE = 8'h08;
  localparam logic [7:0] PTS_OFF_RATE = 8'h0C;
  localparam logic [7:0] PTS_OFF_POS = 8'h10;
  localparam logic [7:0] PTS_OFF_STATUS = 8'h14;
  localparam logic [7:0] PTS_OFF_SYNC = 8'h18;
  localparam logic [1:0] PTS_RESP_OKAY = 2'h0;
  localparam logic [1:0] PTS_RESP_SLVERR = 2'h2;
  // emergency codes per fault: nvm, checksum, internal, sensor (plain defaults)
  localparam logic [15:0] PTS_EMCY_CODE_NVM = 16'hFF00;
  localparam logic [15:0] PTS_EMCY_CODE_CRC = 16'hFF01;
  localparam logic [15:0] PTS_EMCY_CODE_INT = 16'hFF02;
  localparam logic [15:0] PTS_EMCY_CODE_SENSOR = 16'hFF03;
  localparam int unsigned PTS_ERR_GEN_BIT = 0;
  localparam int unsigned PTS_ERR_MFR_BIT = 7;

  typedef enum logic [1:0] {PTS_PDO_IDLE = 2'b01, PTS_PDO_SEND = 2'b10} pts_pdo_fsm_t;
  typedef struct packed {logic [10:0] cob_id; logic [15:0] data;} pts_pdo_t;
  typedef struct packed {logic [10:0] cob_id; logic [15:0] code; logic [7:0] err_reg;} pts_emcy_t;
  typedef struct packed {logic set_node; logic [6:0] node; logic set_rate; logic [2:0] rate;} pts_lss_t;
  typedef struct packed {logic valid; logic [11:0] value;} pts_sample_t;
  typedef struct packed
  {
    logic [16:0] rsv;
    logic [7:0] err_reg;
    logic [3:0] flt_pend;
    logic emcy_busy;
    logic pdo_busy;
    logic pend;
  } pts_status_t;
endpackage

`timescale 1ns/1ps
module pts_timebase #(
  parameter int unsigned MS_CYCLES = pts_pkg::PTS_MS_CYCLES
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // refresh window use
  input wire logic sample_take,
  // time base
  output logic ms_tick,
  output logic sample_open
);
  import pts_pkg::*;

  typedef struct packed
  {
    logic [PTS_DIV_W-1:0] div;
    logic [PTS_REF_W-1:0] ref_ms;
    logic tick;
    logic open;
  } pts_tb_state_t;

  localparam logic [PTS_DIV_W-1:0] DIV_LAST = PTS_DIV_W'(MS_CYCLES - 1);
  localparam logic [PTS_REF_W-1:0] REF_LAST = PTS_REF_W'(PTS_REFRESH_MS - 1);

  pts_tb_state_t s_reg;
  pts_tb_state_t s_next;

  always_comb
  begin
    s_next = s_reg;
    s_next.tick = 1'b0;
    if (s_reg.div == DIV_LAST)
    begin
      s_next.div = '0;
      s_next.tick = 1'b1;
    end
    else
      s_next.div = s_reg.div + 1'b1;
    // clear first so a window opening in the same cycle is not lost
    if (sample_take)
      s_next.open = 1'b0;
    if (s_reg.tick)
    begin
      if (s_reg.ref_ms == REF_LAST)
      begin
        s_next.ref_ms = '0;
        s_next.open = 1'b1;
      end
      else
        s_next.ref_ms = s_reg.ref_ms + 1'b1;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      s_reg <= '0;
    else
      s_reg <= s_next;
  end

  assign ms_tick = s_reg.tick;
  assign sample_open = s_reg.open;

  default clocking tb_cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sample_gate_a: assert property (sample_take |-> sample_open)
    else $error("sample taken outside refresh window");
  tick_single_a: assert property (ms_tick |=> !ms_tick)
    else $error("ms tick longer than one cycle");
endmodule

// ### hdl/pts_scheduler.sv
// top of the position pdo transmit scheduler with its register slave
`timescale 1ns/1ps
module pts_scheduler #(
  parameter int unsigned MS_CYCLES = pts_pkg::PTS_MS_CYCLES
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // converter samples
  input wire pts_pkg::pts_sample_t sample,
  // received requests from the can controller
  input wire logic rtr_req,
  input wire logic sync_req,
  // layer setting service
  input wire pts_pkg::pts_lss_t lss,
  // device fault levels
  input wire logic [3:0] fault_in,
  // transmit pdo
  output pts_pkg::pts_pdo_t pdo,
  output logic pdo_valid,
  input wire logic pdo_ready,
  // emergency message
  output pts_pkg::pts_emcy_t emcy,
  output logic emcy_valid,
  input wire logic emcy_ready,
  // link configuration
  output logic [6:0] node_id,
  output logic [2:0] rate_code
);
  import pts_pkg::*;

  typedef struct packed
  {
    logic aw_got;
    logic [7:0] aw_addr;
    logic w_got;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [7:0] tx_type;
    logic [16:0] cycle_ms;
    logic [6:0] node;
    logic [2:0] rate;
    logic [11:0] pos;
    logic [11:0] last_sent;
    logic [7:0] sync_cnt;
    logic [16:0] cyc_cnt;
    logic pend;
    pts_pdo_fsm_t pdo_st;
    pts_pdo_t pdo;
    logic [3:0] fault_q;
    logic [3:0] flt_pend;
    logic emcy_valid;
    pts_emcy_t emcy;
  } pts_state_t;

  localparam pts_state_t ST_RESET = '{
    tx_type: PTS_TT_RESET,
    node: PTS_NODE_RESET,
    rate: PTS_RATE_20K,
    pos: PTS_POS_MID,
    last_sent: PTS_POS_MID,
    pdo_st: PTS_PDO_IDLE,
    default: '0
  };

  function automatic logic [31:0] pts_wmerge(input logic [31:0] old, input logic [31:0] nv,
                                             input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < PTS_LANES; i++)
    begin
      if (strb[i])
        r[i*PTS_BYTE_W +: PTS_BYTE_W] = nv[i*PTS_BYTE_W +: PTS_BYTE_W];
    end
    return r;
  endfunction

  function automatic logic pts_is_async(input logic [7:0] tt);
    return tt >= PTS_TT_ASYNC_MFR;
  endfunction

  function automatic logic pts_is_sync_cyc(input logic [7:0] tt);
    return (tt != PTS_TT_SYNC_ACYC) && (tt <= PTS_TT_SYNC_MAX);
  endfunction

  function automatic logic pts_is_polled(input logic [7:0] tt);
    return (tt == PTS_TT_RTR_SYNC) || (tt == PTS_TT_RTR_ASYNC);
  endfunction

  function automatic logic [15:0] pts_emcy_code(input logic [1:0] idx);
    logic [15:0] c;
    c = PTS_EMCY_CODE_NVM;
    unique case (idx)
      2'h0: c = PTS_EMCY_CODE_NVM;
      2'h1: c = PTS_EMCY_CODE_CRC;
      2'h2: c = PTS_EMCY_CODE_INT;
      2'h3: c = PTS_EMCY_CODE_SENSOR;
    endcase
    return c;
  endfunction

  pts_state_t s_reg;
  pts_state_t s_next;
  logic ms_tick;
  logic sample_open;
  logic sample_take;
  logic trig;
  logic load;
  logic wr_fire;
  logic [7:0] sync_inc;
  logic [31:0] wv;
  logic [3:0] rise;
  logic [3:0] flt_clr;
  logic [1:0] flt_idx;
  logic [7:0] err_now;
  pts_status_t stat;

  pts_timebase #(
    .MS_CYCLES(MS_CYCLES)
  ) u_timebase (
    .aclk(aclk),
    .aresetn(aresetn),
    .sample_take(sample_take),
    .ms_tick(ms_tick),
    .sample_open(sample_open)
  );

  assign sample_take = sample.valid & sample_open;
  assign s_axi_awready = ~s_reg.aw_got & ~s_reg.bvalid;
  assign s_axi_wready = ~s_reg.w_got & ~s_reg.bvalid;
  assign s_axi_arready = ~s_reg.rvalid;

  always_comb
  begin
    s_next = s_reg;
    trig = 1'b0;
    wv = '0;
    flt_idx = '0;
    flt_clr = '0;
    sync_inc = s_reg.sync_cnt + 1'b1;
    // straight binary, no scaling; mid-scale sits at the reference position
    if (sample_take)
      s_next.pos = sample.value;
    if (lss.set_node && (lss.node >= PTS_NODE_MIN))
      s_next.node = lss.node;
    if (lss.set_rate && (lss.rate <= PTS_RATE_1M))
      s_next.rate = lss.rate;

    // transmit triggers; a remote frame is answered in every mode
    if (rtr_req)
      trig = 1'b1;
    if (pts_is_async(s_reg.tx_type))
    begin
      if (s_reg.cycle_ms == '0)
      begin
        if (s_reg.pos != s_reg.last_sent)
          trig = 1'b1;
      end
      else if (ms_tick)
      begin
        if (s_reg.cyc_cnt <= PTS_CYC_LAST)
          trig = 1'b1;
        else
          s_next.cyc_cnt = s_reg.cyc_cnt - 1'b1;
      end
    end
    if (sync_req && pts_is_sync_cyc(s_reg.tx_type))
    begin
      if (sync_inc >= s_reg.tx_type)
      begin
        trig = 1'b1;
        s_next.sync_cnt = '0;
      end
      else
        s_next.sync_cnt = sync_inc;
    end
    if (sync_req && (s_reg.tx_type == PTS_TT_SYNC_ACYC) && (s_reg.pos != s_reg.last_sent))
      trig = 1'b1;

    // a trigger while busy stays pending, so it is never lost
    load = (s_reg.pdo_st == PTS_PDO_IDLE) && (s_reg.pend || trig);
    s_next.pend = (s_reg.pend | trig) & ~load;
    unique case (s_reg.pdo_st)
      PTS_PDO_IDLE:
      begin
        if (load)
        begin
          s_next.pdo_st = PTS_PDO_SEND;
          s_next.pdo.cob_id = PTS_COB_PDO + {4'h0, s_reg.node};
          s_next.pdo.data = {PTS_POS_PAD, s_reg.pos};
          s_next.last_sent = s_reg.pos;
          s_next.cyc_cnt = s_reg.cycle_ms;
        end
      end
      PTS_PDO_SEND:
      begin
        if (pdo_ready)
          s_next.pdo_st = PTS_PDO_IDLE;
      end
    endcase

    // emergency: rising fault edges queue, lowest index goes first
    err_now = '0;
    if (|fault_in)
    begin
      err_now[PTS_ERR_GEN_BIT] = 1'b1;
      err_now[PTS_ERR_MFR_BIT] = 1'b1;
    end
    s_next.fault_q = fault_in;
    rise = fault_in & ~s_reg.fault_q;
    if (s_reg.emcy_valid && emcy_ready)
      s_next.emcy_valid = 1'b0;
    if (!s_reg.emcy_valid && (|s_reg.flt_pend))
    begin
      for (int i = PTS_NFAULT - 1; i >= 0; i--)
      begin
        if (s_reg.flt_pend[i])
          flt_idx = 2'(i);
      end
      flt_clr[flt_idx] = 1'b1;
      s_next.emcy_valid = 1'b1;
      s_next.emcy.cob_id = PTS_COB_EMCY + {4'h0, s_reg.node};
      s_next.emcy.code = pts_emcy_code(flt_idx);
      s_next.emcy.err_reg = err_now;
    end
    s_next.flt_pend = (s_reg.flt_pend & ~flt_clr) | rise;

    // register writes come last so software wins over the sync counter
    if (s_axi_awvalid && s_axi_awready)
    begin
      s_next.aw_got = 1'b1;
      s_next.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      s_next.w_got = 1'b1;
      s_next.w_data = s_axi_wdata;
      s_next.w_strb = s_axi_wstrb;
    end
    if (s_reg.bvalid && s_axi_bready)
      s_next.bvalid = 1'b0;
    wr_fire = s_reg.aw_got & s_reg.w_got & ~s_reg.bvalid;
    if (wr_fire)
    begin
      s_next.aw_got = 1'b0;
      s_next.w_got = 1'b0;
      s_next.bvalid = 1'b1;
      s_next.bresp = PTS_RESP_OKAY;
      case (s_reg.aw_addr)
        PTS_OFF_TX_TYPE:
        begin
          wv = pts_wmerge({24'h0, s_reg.tx_type}, s_reg.w_data, s_reg.w_strb);
          if ((wv[31:8] == '0) && ((wv[7:0] <= PTS_TT_SYNC_MAX) || (wv[7:0] >= PTS_TT_RTR_SYNC)))
          begin
            s_next.tx_type = wv[7:0];
            s_next.sync_cnt = '0;
          end
          else
            s_next.bresp = PTS_RESP_SLVERR;
        end
        PTS_OFF_CYCLE:
        begin
          wv = pts_wmerge({15'h0, s_reg.cycle_ms}, s_reg.w_data, s_reg.w_strb);
          // the running countdown keeps its value until the next reload
          if (wv <= {15'h0, PTS_CYCLE_MAX})
            s_next.cycle_ms = wv[16:0];
          else
            s_next.bresp = PTS_RESP_SLVERR;
        end
        PTS_OFF_NODE:
        begin
          wv = pts_wmerge({25'h0, s_reg.node}, s_reg.w_data, s_reg.w_strb);
          if ((wv[31:7] == '0) && (wv[6:0] >= PTS_NODE_MIN))
            s_next.node = wv[6:0];
          else
            s_next.bresp = PTS_RESP_SLVERR;
        end
        PTS_OFF_RATE:
        begin
          wv = pts_wmerge({29'h0, s_reg.rate}, s_reg.w_data, s_reg.w_strb);
          if (wv <= {29'h0, PTS_RATE_800K})
            s_next.rate = wv[2:0];
          else
            s_next.bresp = PTS_RESP_SLVERR;
        end
        default: s_next.bresp = PTS_RESP_SLVERR;
      endcase
    end

    // reads
    stat = '0;
    stat.err_reg = err_now;
    stat.flt_pend = s_reg.flt_pend;
    stat.emcy_busy = s_reg.emcy_valid;
    stat.pdo_busy = (s_reg.pdo_st == PTS_PDO_SEND);
    stat.pend = s_reg.pend;
    if (s_reg.rvalid && s_axi_rready)
      s_next.rvalid = 1'b0;
    if (s_axi_arvalid && s_axi_arready)
    begin
      s_next.rvalid = 1'b1;
      s_next.rresp = PTS_RESP_OKAY;
      case (s_axi_araddr)
        PTS_OFF_TX_TYPE: s_next.rdata = {24'h0, s_reg.tx_type};
        PTS_OFF_CYCLE: s_next.rdata = {15'h0, s_reg.cycle_ms};
        PTS_OFF_NODE: s_next.rdata = {25'h0, s_reg.node};
        PTS_OFF_RATE: s_next.rdata = {29'h0, s_reg.rate};
        PTS_OFF_POS: s_next.rdata = {20'h0, s_reg.pos};
        PTS_OFF_STATUS: s_next.rdata = stat;
        PTS_OFF_SYNC: s_next.rdata = {24'h0, s_reg.sync_cnt};
        default:
        begin
          s_next.rdata = '0;
          s_next.rresp = PTS_RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      s_reg <= ST_RESET;
    else
      s_reg <= s_next;
  end

  assign s_axi_bvalid = s_reg.bvalid;
  assign s_axi_bresp = s_reg.bresp;
  assign s_axi_rvalid = s_reg.rvalid;
  assign s_axi_rdata = s_reg.rdata;
  assign s_axi_rresp = s_reg.rresp;
  assign pdo = s_reg.pdo;
  assign pdo_valid = (s_reg.pdo_st == PTS_PDO_SEND);
  assign emcy = s_reg.emcy;
  assign emcy_valid = s_reg.emcy_valid;
  assign node_id = s_reg.node;
  assign rate_code = s_reg.rate;

  default clocking sch_cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence pdo_start_s;
    !pdo_valid ##1 pdo_valid;
  endsequence

  sequence pdo_none_s;
    ##1 !$rose(pdo_valid);
  endsequence

  rtr_answer_a: assert property (rtr_req && !pdo_valid |-> pdo_start_s)
    else $error("remote frame not answered next cycle");
  polled_quiet_a: assert property (pts_is_polled(s_reg.tx_type)
    && !rtr_req && !s_reg.pend |-> pdo_none_s)
    else $error("polled mode sent without request");
  change_send_a: assert property (pts_is_async(s_reg.tx_type)
    && (s_reg.cycle_ms == '0) && (s_reg.pos != s_reg.last_sent) && !pdo_valid |-> pdo_start_s)
    else $error("value change not sent");
  cycle_expire_a: assert property (pts_is_async(s_reg.tx_type) && ms_tick
    && (s_reg.cycle_ms != '0) && (s_reg.cyc_cnt <= PTS_CYC_LAST) && !pdo_valid |-> pdo_start_s)
    else $error("cycle expiry not sent");
  sync_send_a: assert property (sync_req && pts_is_sync_cyc(s_reg.tx_type)
    && (sync_inc >= s_reg.tx_type) && !pdo_valid |-> pdo_start_s)
    else $error("sync not answered");
  sync_count_a: assert property (sync_req && pts_is_sync_cyc(s_reg.tx_type)
    && (sync_inc < s_reg.tx_type) && !rtr_req && !s_reg.pend
    |-> pdo_none_s ##0 (s_reg.sync_cnt == $past(sync_inc)))
    else $error("sync count not honoured");
  acyc_quiet_a: assert property (sync_req && (s_reg.tx_type == PTS_TT_SYNC_ACYC)
    && (s_reg.pos == s_reg.last_sent) && !rtr_req && !s_reg.pend |-> pdo_none_s)
    else $error("unchanged value sent in acyclic mode");
  pack_zero_a: assert property (pdo_valid
    |-> (pdo.data[15:12] == PTS_POS_PAD) && (pdo.data[11:0] == s_reg.last_sent))
    else $error("pdo payload packing wrong");
  pdo_hold_a: assert property (pdo_valid && !pdo_ready
    |=> pdo_valid && $stable(pdo))
    else $error("pdo dropped before taken");
  node_range_a: assert property (node_id >= PTS_NODE_MIN)
    else $error("node address out of range");
  rate_range_a: assert property (rate_code <= PTS_RATE_1M)
    else $error("rate code out of range");
  reload_send_a: assert property ($rose(pdo_valid)
    |-> s_reg.cyc_cnt == $past(s_reg.cycle_ms))
    else $error("cycle countdown not reloaded on send");
  emcy_raise_a: assert property ($rose(fault_in[0]) && !emcy_valid
    && (s_reg.flt_pend == '0) |-> ##2 emcy_valid && (emcy.code == PTS_EMCY_CODE_NVM))
    else $error("fault did not raise emergency");
endmodule

// ### test/pts_can_master.sv
// can master model: sync and remote frame source, pdo and emergency sink
`timescale 1ns/1ps
module pts_can_master
  import pts_pkg::*;
(
  // clock
  input wire logic aclk,
  // requests to the node
  output logic rtr_req,
  output logic sync_req,
  // messages from the node
  input wire pts_pkg::pts_pdo_t pdo,
  input wire logic pdo_valid,
  output logic pdo_ready,
  input wire pts_pkg::pts_emcy_t emcy,
  input wire logic emcy_valid,
  output logic emcy_ready,
  // stall control
  input wire logic slow
);
  int n_pdo = 0;
  int n_emcy = 0;
  pts_pdo_t last_pdo;
  pts_emcy_t last_emcy;
  logic [1:0] stall = 2'h0;
  initial {rtr_req, sync_req, pdo_ready, emcy_ready} = 4'h0;
  // one-cycle flag, as a controller marks a received frame
  task automatic pulse(input logic sync);
    @(posedge aclk);
    if (sync)
      sync_req <= 1'b1;
    else
      rtr_req <= 1'b1;
    @(posedge aclk);
    sync_req <= 1'b0;
    rtr_req <= 1'b0;
  endtask
  // a slow pdo sink stalls three cycles in four, the emergency sink two in four, as a busy bus would
  always @(posedge aclk)
  begin
    stall <= stall + 2'h1;
    pdo_ready <= !slow || stall == 2'h3;
    emcy_ready <= !slow || stall[0];
    if (pdo_valid && pdo_ready)
    begin
      n_pdo <= n_pdo + 1;
      last_pdo <= pdo;
    end
    if (emcy_valid && emcy_ready)
    begin
      n_emcy <= n_emcy + 1;
      last_emcy <= emcy;
    end
  end
endmodule

// ### test/tb.sv
// self-checking bench for the position pdo transmit scheduler
`timescale 1ns/1ps
module tb;
  import pts_pkg::*;
  localparam int unsigned MS = 40;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic slow = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, rtr_req, sync_req;
  logic pdo_valid, pdo_ready, emcy_valid, emcy_ready;
  logic [1:0] bresp, rresp, resp;
  logic [31:0] rdata, r, cnt;
  logic [31:0] seed = 32'h4bff;
  logic [6:0] node_id;
  logic [2:0] rate_code;
  logic [11:0] v;
  pts_sample_t sample = '0;
  pts_lss_t lss = '0;
  logic [3:0] fault_in = 4'h0;
  pts_pdo_t pdo;
  pts_emcy_t emcy;
  int miscompares = 0;
  int n_checks = 0;
  int n0;
  always #12.5 aclk = ~aclk;
  pts_scheduler #(.MS_CYCLES(MS)) dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .sample(sample), .rtr_req(rtr_req), .sync_req(sync_req), .lss(lss), .fault_in(fault_in),
    .pdo(pdo), .pdo_valid(pdo_valid), .pdo_ready(pdo_ready), .emcy(emcy),
    .emcy_valid(emcy_valid), .emcy_ready(emcy_ready), .node_id(node_id), .rate_code(rate_code));
  pts_can_master m (.aclk(aclk), .rtr_req(rtr_req), .sync_req(sync_req), .pdo(pdo),
    .pdo_valid(pdo_valid), .pdo_ready(pdo_ready), .emcy(emcy), .emcy_valid(emcy_valid),
    .emcy_ready(emcy_ready), .slow(slow));
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  // a fresh position that always differs from the one given
  function automatic logic [11:0] next_pos(input logic [11:0] p, input logic [31:0] s);
    return p ^ (s[11:0] | 12'h001);
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one register access; address and data are offered together
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    araddr <= a;
    wdata <= d;
    awvalid <= w;
    wvalid <= w;
    bready <= w;
    arvalid <= !w;
    rready <= !w;
    do
    begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (arready) arvalid <= 1'b0;
    end while (!(w ? bvalid : rvalid));
    r = rdata;
    resp = w ? bresp : rresp;
    bready <= 1'b0;
    rready <= 1'b0;
  endtask
  task automatic wait_pdo(input int n);
    repeat (2000)
      if (m.n_pdo < n) @(posedge aclk);
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    #(25 * 20000);
    miscompares++;
    summarize();
  end
  initial
  begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    bus(0, PTS_OFF_NODE, 0);
    chk(r, 1);
    bus(0, PTS_OFF_RATE, 0);
    chk(r, 0);
    bus(0, PTS_OFF_POS, 0);
    chk(r, 32'h800);
    bus(1, 8'h40, 32'h1);
    chk(resp, 2);
    bus(1, PTS_OFF_NODE, 0);
    chk(resp, 2);
    bus(1, PTS_OFF_RATE, 6);
    chk(resp, 2);
    bus(1, PTS_OFF_CYCLE, 32'h10001);
    chk(resp, 2);
    bus(1, PTS_OFF_CYCLE, 32'h10000);
    bus(0, PTS_OFF_CYCLE, 0);
    chk(r, 32'h10000);
    bus(1, PTS_OFF_CYCLE, 0);
    bus(1, PTS_OFF_NODE, 32'h23);
    chk(node_id, 7'h23);
    bus(1, PTS_OFF_TX_TYPE, 32'hFD);
    chk(resp, 0);
    // polled: a new value alone must not send
    slow <= 1'b1;
    n0 = m.n_pdo;
    seed = xs(seed);
    v = seed[11:0];
    sample <= {1'b1, v};
    repeat (11 * MS) @(posedge aclk);
    chk(m.n_pdo, n0);
    bus(0, PTS_OFF_POS, 0);
    chk(r, v);
    m.pulse(0);
    wait_pdo(n0 + 1);
    chk(m.n_pdo, n0 + 1);
    chk(m.last_pdo.data, {4'h0, v});
    chk(m.last_pdo.cob_id, 11'h1A3);
    slow <= 1'b0;
    // change mode, with a second value offered inside the refresh gap
    bus(1, PTS_OFF_TX_TYPE, 32'hFE);
    n0 = m.n_pdo;
    seed = xs(seed);
    v = next_pos(v, seed);
    sample.value <= v;
    wait_pdo(n0 + 1);
    chk(m.last_pdo.data, {4'h0, v});
    seed = xs(seed);
    v = next_pos(v, seed);
    sample.value <= v;
    repeat (8 * MS) @(posedge aclk);
    chk(m.n_pdo, n0 + 1);
    wait_pdo(n0 + 2);
    chk(m.last_pdo.data, {4'h0, v});
    // cycle timer, new period taken at a reload
    for (int p = 3; p > 0; p -= 2)
    begin
      bus(1, PTS_OFF_CYCLE, p);
      repeat (4 * MS) @(posedge aclk);
      n0 = m.n_pdo;
      repeat (30 * MS) @(posedge aclk);
      cnt = m.n_pdo - n0;
      chk(cnt + 1 >= 30 / p && cnt <= 30 / p + 1, 1);
    end
    bus(1, PTS_OFF_CYCLE, 0);
    bus(1, PTS_OFF_TX_TYPE, 32'h03);
    n0 = m.n_pdo;
    for (int i = 1; i <= 6; i++)
    begin
      m.pulse(1);
      repeat (4) @(posedge aclk);
      chk(m.n_pdo, n0 + i / 3);
      bus(0, PTS_OFF_SYNC, 0);
      chk(r, i % 3);
    end
    bus(1, PTS_OFF_TX_TYPE, 32'h00);
    m.pulse(1);
    repeat (4) @(posedge aclk);
    chk(m.n_pdo, n0 + 2);
    seed = xs(seed);
    v = next_pos(v, seed);
    sample.value <= v;
    repeat (11 * MS) @(posedge aclk);
    m.pulse(1);
    repeat (4) @(posedge aclk);
    chk(m.n_pdo, n0 + 3);
    chk(m.last_pdo.data, {4'h0, v});
    for (int i = 0; i < 4; i++)
    begin
      fault_in <= fault_in | (4'h1 << i);
      repeat (10) @(posedge aclk);
      chk(m.n_emcy, i + 1);
      chk({m.last_emcy.cob_id, m.last_emcy.code}, {11'h0A3, 16'hFF00 + 16'(i)});
      chk(m.last_emcy.err_reg, 8'h81);
    end
    // generic and maker bits of the error byte, nothing left pending
    bus(0, PTS_OFF_STATUS, 0);
    chk(r, 32'h4080);
    lss <= {1'b1, 7'h05, 1'b1, 3'h6};
    @(posedge aclk);
    lss <= '0;
    repeat (2) @(posedge aclk);
    chk(node_id, 7'h05);
    chk(rate_code, 3'h6);
    summarize();
  end
endmodule
